// File: design/lcr_consts.vh
// Constants for the link control configuration register bank.
// Assumes a 200 MHz device clock and 8-bit register access.
`ifndef LCR_CONSTS_VH
`define LCR_CONSTS_VH

// Register offsets.
`define LCR_OFS_GENERAL 8'h03
`define LCR_OFS_TIMEOUT 8'h04
`define LCR_OFS_SERIAL 8'h05
`define LCR_OFS_RESET 8'h01

// Reset values.
`define LCR_RST_GENERAL 8'hF0
`define LCR_RST_TIMEOUT 8'hFE
`define LCR_RST_SERIAL 8'h1E

// Field positions.
`define LCR_BIT_CRC 6
`define LCR_BIT_PULL 5
`define LCR_BIT_FILTER 4
`define LCR_BIT_FWD_MATCH 3
`define LCR_BIT_AUTO_ACK 2
`define LCR_BIT_GATE 1
`define LCR_BIT_TO_OFF 0
`define LCR_BIT_FWD_ALL 7
`define LCR_BIT_FULL_RESET 1

// Timing: timeout unit 2 ms at 5 ns period.
`define LCR_CLK_PERIOD_NS 5
`define LCR_TO_UNIT_NS 2000000
`define LCR_TO_UNIT_CYC (`LCR_TO_UNIT_NS / `LCR_CLK_PERIOD_NS)
`define LCR_HOLD_UNIT_NS 50
`define LCR_HOLD_UNIT_CYC (`LCR_HOLD_UNIT_NS / `LCR_CLK_PERIOD_NS)
`define LCR_GLITCH_UNIT_NS 5
`define LCR_GLITCH_UNIT_CYC (`LCR_GLITCH_UNIT_NS / `LCR_CLK_PERIOD_NS)
`define LCR_FILTER_SINGLE 3'h2
`define LCR_FILTER_DUAL 3'h4

`endif

// File: design/lcr_timeout.v
// Control channel watchdog: counts 2 ms ticks while a transaction runs.
// Assumes busy is a same-clock level held for the whole transaction.
`timescale 1ns/10ps
`include "lcr_consts.vh"
module lcr_timeout #(
    parameter UNIT_CYC = `LCR_TO_UNIT_CYC
) (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    input wire softReset,
    // Settings.
    input wire [6:0] limit,
    input wire stopCount,
    // Transaction state.
    input wire busy,
    output reg expire
);

reg [18:0] unitCount;
reg [6:0] tickCount;
wire tick;

// ----------------------------------------------------------------
// Tick divider and counter
// ----------------------------------------------------------------
assign tick = (unitCount == UNIT_CYC - 1);

// terminate late transactions.
// Count only while busy; a limit of zero never expires, which is safer
// than killing every transaction at once.
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        unitCount <= 19'h00000;
        tickCount <= 7'h00;
        expire <= 1'b0;
    end else if (softReset || !busy || stopCount) begin
        unitCount <= 19'h00000;
        tickCount <= 7'h00;
        expire <= 1'b0;
    end else begin
        expire <= 1'b0;
        if (tick) begin
            unitCount <= 19'h00000;
            if (tickCount + 7'h01 == limit && limit != 7'h00) begin
                expire <= 1'b1;
                tickCount <= 7'h00;
            end else begin
                tickCount <= tickCount + 7'h01;
            end
        end else begin
            unitCount <= unitCount + 19'h00001;
        end
    end
end

endmodule

// File: design/lcr_regs.v
// Link control configuration registers with byte access, sync pulse
// filtering and the control channel watchdog.
// Assumes an on-chip serial-bus slave delivers byte reads and writes.
`timescale 1ns/10ps
`include "lcr_consts.vh"
module lcr_regs (
    // Clock and reset.
    input wire clk,
    input wire rst_n,
    // Register access from the serial-bus slave.
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    // Link state.
    input wire dualLane,
    input wire protectedPeer,
    input wire addrMatch,
    input wire ctrlBusy,
    // Raw sync and valid pins.
    input wire dataValidPin,
    input wire lineSyncPin,
    input wire frameSyncPin,
    // Settings delivered to the datapath.
    output reg backCrcGenOn,
    output reg undrivenInputPullDir,
    output reg forwardTransaction,
    output reg autoAck,
    output reg pixelGateByValid,
    output reg [2:0] holdTime,
    output reg [3:0] glitchDepth,
    // Filtered sync and valid, watchdog abort.
    output reg dataValid,
    output reg lineSync,
    output reg frameSync,
    output reg ctrlAbort
);

reg [7:0] generalCfg;
reg [7:0] timeoutCtrl;
reg [7:0] serialCtrl;
reg softReset;
reg [2:0] syncMeta;
reg [2:0] syncIn;
reg [2:0] syncLast;
reg [2:0] runLen0;
reg [2:0] runLen1;
reg [2:0] runLen2;
wire expire;
wire [2:0] filterLen;

// ----------------------------------------------------------------
// Register file
// ----------------------------------------------------------------
// full logic reset.
// The reset bit self-clears; its pulse reloads the general, timeout and serial registers next cycle.
// reserved bits stored.
// All eight bits of the general, timeout and serial registers are writable, so reserved bits keep
// whatever was written.
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        generalCfg <= `LCR_RST_GENERAL;
        timeoutCtrl <= `LCR_RST_TIMEOUT;
        serialCtrl <= `LCR_RST_SERIAL;
        softReset <= 1'b0;
    end else if (softReset) begin
        generalCfg <= `LCR_RST_GENERAL;
        timeoutCtrl <= `LCR_RST_TIMEOUT;
        serialCtrl <= `LCR_RST_SERIAL;
        softReset <= 1'b0;
    end else if (regWrite) begin
        case (regAddr)
            `LCR_OFS_GENERAL: generalCfg <= regWdata;
            `LCR_OFS_TIMEOUT: timeoutCtrl <= regWdata;
            `LCR_OFS_SERIAL: serialCtrl <= regWdata;
            `LCR_OFS_RESET: softReset <= regWdata[`LCR_BIT_FULL_RESET];
            default: softReset <= 1'b0;
        endcase
    end
end

// Read data; the reset bit always reads zero, unmapped reads zero.
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        regRdata <= 8'h00;
    end else if (regRead) begin
        case (regAddr)
            `LCR_OFS_GENERAL: regRdata <= generalCfg;
            `LCR_OFS_TIMEOUT: regRdata <= timeoutCtrl;
            `LCR_OFS_SERIAL: regRdata <= serialCtrl;
            default: regRdata <= 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------
// Settings outputs
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        backCrcGenOn <= 1'b1;
        undrivenInputPullDir <= 1'b1;
        forwardTransaction <= 1'b0;
        autoAck <= 1'b0;
        pixelGateByValid <= 1'b0;
        holdTime <= 3'h1;
        glitchDepth <= 4'hE;
    end else begin
        backCrcGenOn <= generalCfg[`LCR_BIT_CRC];
        undrivenInputPullDir <= generalCfg[`LCR_BIT_PULL];
        forwardTransaction <= serialCtrl[`LCR_BIT_FWD_ALL] ||
            (generalCfg[`LCR_BIT_FWD_MATCH] && addrMatch);
        autoAck <= generalCfg[`LCR_BIT_AUTO_ACK];
        // pixel gating policy.
        // A protected peer forces gating, so the bit only matters otherwise.
        pixelGateByValid <= protectedPeer || generalCfg[`LCR_BIT_GATE];
        holdTime <= serialCtrl[6:4];
        glitchDepth <= serialCtrl[3:0];
    end
end

// ----------------------------------------------------------------
// Sync and valid pulse filter
// ----------------------------------------------------------------
// Pins are asynchronous, so two flops precede the filter.
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        syncMeta <= 3'h0;
        syncIn <= 3'h0;
    end else begin
        syncMeta <= {frameSyncPin, lineSyncPin, dataValidPin};
        syncIn <= syncMeta;
    end
end

assign filterLen = dualLane ? `LCR_FILTER_DUAL : `LCR_FILTER_SINGLE;

// Saturating run length of the current level.
function [2:0] nextRun;
    input [2:0] run;
    input same;
    begin
        if (!same)
            nextRun = 3'h1;
        else if (run == 3'h7)
            nextRun = run;
        else
            nextRun = run + 3'h1;
    end
endfunction

// reject short pulses.
// With the filter bit set, a new level passes only after it held filterLen clocks; this costs a
// fixed latency of filterLen - 1 clocks on every edge.
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        syncLast <= 3'h0;
        runLen0 <= 3'h0;
        runLen1 <= 3'h0;
        runLen2 <= 3'h0;
        dataValid <= 1'b0;
        lineSync <= 1'b0;
        frameSync <= 1'b0;
    end else begin
        syncLast <= syncIn;
        runLen0 <= nextRun(runLen0, syncIn[0] == syncLast[0]);
        runLen1 <= nextRun(runLen1, syncIn[1] == syncLast[1]);
        runLen2 <= nextRun(runLen2, syncIn[2] == syncLast[2]);
        if (!generalCfg[`LCR_BIT_FILTER]) begin
            dataValid <= syncIn[0];
            lineSync <= syncIn[1];
            frameSync <= syncIn[2];
        end else begin
            if (nextRun(runLen0, syncIn[0] == syncLast[0]) >= filterLen)
                dataValid <= syncIn[0];
            if (nextRun(runLen1, syncIn[1] == syncLast[1]) >= filterLen)
                lineSync <= syncIn[1];
            if (nextRun(runLen2, syncIn[2] == syncLast[2]) >= filterLen)
                frameSync <= syncIn[2];
        end
    end
end

// ----------------------------------------------------------------
// Control channel watchdog
// ----------------------------------------------------------------
// timeout field.
lcr_timeout u_timeout (
    .clk(clk),
    .rst_n(rst_n),
    .softReset(softReset),
    .limit(timeoutCtrl[7:1]),
    .stopCount(timeoutCtrl[`LCR_BIT_TO_OFF]),
    .busy(ctrlBusy),
    .expire(expire)
);

always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
        ctrlAbort <= 1'b0;
    else
        ctrlAbort <= expire;
end

endmodule

// File: verif/lcr_regs_monitor.sv
// Port checker for the link control register bank.
// Assumes it is bound to lcr_regs and sees only its ports.
`timescale 1ns/10ps
module lcr_regs_monitor (
    // Clock, reset and register access.
    input wire clk,
    input wire rst_n,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    // Link state, pins and settings.
    input wire protectedPeer,
    input wire ctrlBusy,
    input wire dataValidPin,
    input wire backCrcGenOn,
    input wire undrivenInputPullDir,
    input wire autoAck,
    input wire pixelGateByValid,
    input wire [2:0] holdTime,
    input wire [3:0] glitchDepth,
    input wire dataValid,
    input wire ctrlAbort
);
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    gate_force_a: assert property (
        protectedPeer [*3] |-> pixelGateByValid)
        else $error("Gating not forced by a protected peer.");
    unmapped_read_a: assert property (
        regRead && (regAddr < 8'h03 || regAddr > 8'h05) |=> regRdata == 8'h00)
        else $error("Unmapped read returned data.");
    rdata_hold_a: assert property (
        !regRead |=> $stable(regRdata))
        else $error("Read data moved without a read.");
    // A write in the cycle after a full logic reset request is lost.
    general_write_a: assert property (
        regWrite && regAddr == 8'h03 &&
        !$past(regWrite && regAddr == 8'h01 && regWdata[1]) |-> ##2
        (backCrcGenOn == $past(regWdata[6], 2) && autoAck ==
        $past(regWdata[2], 2) && undrivenInputPullDir == $past(regWdata[5], 2)))
        else $error("General settings did not follow a write.");
    serial_write_a: assert property (
        regWrite && regAddr == 8'h05 &&
        !$past(regWrite && regAddr == 8'h01 && regWdata[1]) |-> ##2 (holdTime ==
        $past(regWdata[6:4], 2) && glitchDepth == $past(regWdata[3:0], 2)))
        else $error("Serial settings did not follow a write.");
    abort_pulse_a: assert property (
        ctrlAbort |=> !ctrlAbort)
        else $error("Abort longer than one cycle.");
    abort_busy_a: assert property (
        ctrlAbort |-> $past(ctrlBusy))
        else $error("Abort without a transaction.");
    valid_rise_a: assert property (
        $rose(dataValid) |-> $past(dataValidPin, 3))
        else $error("Valid rose without a pin level.");
endmodule

bind lcr_regs lcr_regs_monitor uMon (.clk, .rst_n, .regWrite, .regRead,
    .regAddr, .regWdata, .regRdata, .protectedPeer, .ctrlBusy, .dataValidPin,
    .backCrcGenOn, .undrivenInputPullDir, .autoAck, .pixelGateByValid,
    .holdTime, .glitchDepth, .dataValid, .ctrlAbort);

// File: verif/lcr_peer_model.sv
// Remote serializer stand-in: drives decode match and busy levels.
// Assumes the bench calls its tasks at falling clock edges.
`timescale 1ns/10ps
module lcr_peer_model (
    // Clock.
    input wire clk,
    // Control channel state towards the bank.
    output logic ctrlBusy,
    output logic addrMatch
);
    // Idle link: no transaction and no decode hit.
    initial begin
        ctrlBusy = 1'b0;
        addrMatch = 1'b0;
    end
    task automatic decode(input logic m);
        addrMatch = m;
    endtask
    // Busy is a level for the whole transaction, as the bank expects.
    task automatic transact(input int n);
        ctrlBusy = 1'b1;
        repeat (n) @(negedge clk);
        ctrlBusy = 1'b0;
    endtask
endmodule

// File: verif/link_control_config_regs_test.sv
// Self-checking bench for the link control register bank.
// Assumes the watchdog unit is shortened to 10 clocks so expiry is reached.
`timescale 1ns/10ps
module link_control_config_regs_test;
    logic clk, rst_n, regWrite, regRead, dualLane, protectedPeer, pin;
    logic [7:0] regAddr, regWdata;
    wire [7:0] regRdata;
    wire addrMatch, ctrlBusy, backCrc, pull, fwd, autoAck, gate;
    wire dataValid, lineSync, frameSync, ctrlAbort;
    wire [2:0] holdTime;
    wire [3:0] glitchDepth;
    int fail_count = 0;
    int cmp_count = 0;

    lcr_regs DUT (.clk, .rst_n, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .dualLane, .protectedPeer, .addrMatch, .ctrlBusy,
        .dataValidPin(pin), .lineSyncPin(pin), .frameSyncPin(pin),
        .backCrcGenOn(backCrc), .undrivenInputPullDir(pull),
        .forwardTransaction(fwd), .autoAck, .pixelGateByValid(gate),
        .holdTime, .glitchDepth, .dataValid, .lineSync, .frameSync,
        .ctrlAbort);
    lcr_peer_model uPeer (.clk, .ctrlBusy, .addrMatch);
    // The real 2 ms unit would outlast the run, so the bench shortens it.
    defparam DUT.u_timeout.UNIT_CYC = 10;

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Settings land one cycle after the write edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge clk);
        regWrite = 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRead = 1'b0;
        @(negedge clk);
        chk(regRdata, exp);
    endtask
    // Busy for n clocks; counts abort pulses seen, allowing some drain time.
    task automatic watch(input int n, input logic [7:0] exp);
        int hits;
        hits = 0;
        fork
            uPeer.transact(n);
            repeat (n + 4) begin
                @(negedge clk);
                if (ctrlAbort === 1'b1) hits++;
            end
        join
        chk(hits[7:0], exp);
    endtask
    // A pulse of n clocks on all three pins; any filtered echo is seen.
    task automatic pulse(input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        pin = 1'b1;
        repeat (n) @(negedge clk);
        pin = 1'b0;
        repeat (8) begin
            @(negedge clk);
            if ((dataValid | lineSync | frameSync) === 1'b1) seen = 1'b1;
        end
        chk({7'h0, seen}, {7'h0, exp});
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence: reset for 20 cycles, then each scenario in turn.
    initial begin
        {regWrite, regRead, dualLane, protectedPeer, pin} = 5'h00;
        regAddr = 8'h00;
        regWdata = 8'h00;
        rst_n = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rd(8'h03, 8'hF0);
        rd(8'h04, 8'hFE);
        rd(8'h05, 8'h1E);
        chk({3'h0, backCrc, pull, autoAck, gate, fwd}, 8'h18);
        pulse(1, 1'b0);
        pulse(2, 1'b1);
        dualLane = 1'b1;
        pulse(3, 1'b0);
        pulse(4, 1'b1);
        wr(8'h03, 8'hE0);
        pulse(1, 1'b1);
        wr(8'h03, 8'h8D);
        rd(8'h03, 8'h8D);
        chk({3'h0, backCrc, pull, autoAck, gate, fwd}, 8'h04);
        uPeer.decode(1'b1);
        repeat (2) @(negedge clk);
        chk({7'h0, fwd}, 8'h01);
        uPeer.decode(1'b0);
        wr(8'h05, 8'hA3);
        chk({1'b0, holdTime, glitchDepth}, 8'h23);
        chk({7'h0, fwd}, 8'h01);
        wr(8'h03, 8'h02);
        chk({7'h0, gate}, 8'h01);
        wr(8'h03, 8'h00);
        protectedPeer = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h0, gate}, 8'h01);
        protectedPeer = 1'b0;
        wr(8'h04, 8'h03);
        rd(8'h04, 8'h03);
        watch(40, 8'h00);
        wr(8'h04, 8'h04);
        watch(15, 8'h00);
        watch(30, 8'h01);
        rd(8'h10, 8'h00);
        wr(8'h01, 8'h02);
        rd(8'h03, 8'hF0);
        rd(8'h05, 8'h1E);
        rd(8'h01, 8'h00);
        test_done;
    end
    // Hang guard: running out counts as a mismatch.
    initial begin
        #100000;
        fail_count++;
        test_done;
    end
endmodule
